// ### common/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  // Register indices on the register port
  localparam logic [1:0] ADDR_CON1 = 2'h0;
  localparam logic [1:0] ADDR_CON2 = 2'h1;
  localparam logic [1:0] ADDR_CON3 = 2'h2;
  // First control register fields
  localparam int CON1_ON = 15;
  localparam int CON1_IDLE_STOP = 13;
  localparam int CON1_DMA_BUILD = 12;
  localparam int CON1_RES12 = 10;
  localparam int CON1_FORM_LO = 8;
  localparam int CON1_TRIG_LO = 5;
  localparam int CON1_SIMULTANEOUS_SAMPLE = 3;
  localparam int CON1_AUTO_SAMPLE_START = 2;
  localparam int CON1_SAMPLE_BIT = 1;
  localparam int CON1_DONE = 0;
  // Second control register fields
  localparam int CON2_VREF_LO = 13;
  localparam int CON2_SCAN = 10;
  localparam int CON2_CHCNT_LO = 8;
  localparam int CON2_BUFFER_FILL_STATUS = 7;
  localparam int CON2_RATE_LO = 2;
  localparam int CON2_SPLIT_BUFFER_MODE = 1;
  localparam int CON2_ALTERNATE_SAMPLE = 0;
  // Third control register fields
  localparam int CON3_RC = 15;
  localparam int CON3_SAMC_LO = 8;
  localparam int CON3_DIV_LO = 0;
  // Storage masks and reset values
  localparam logic [15:0] CON1_STORE_MASK = 16'hb7ec;
  localparam logic [15:0] CON2_STORE_MASK = 16'he73f;
  localparam logic [15:0] CON3_STORE_MASK = 16'h9fff;
  localparam logic [15:0] CON_RESET = 16'h0000;
  // Conversion length in conversion-clock periods, and the upper buffer half start
  localparam logic [4:0] CONV_TAD_10B = 5'h0c;
  localparam logic [4:0] CONV_TAD_12B = 5'h0e;
  localparam logic [3:0] HALF_BASE = 4'h8;

  typedef enum logic [2:0] {
    TRIG_SOFT = 3'b000,
    TRIG_INT0 = 3'b001,
    TRIG_TMR3 = 3'b010,
    TRIG_PWM1 = 3'b011,
    TRIG_TMR5 = 3'b100,
    TRIG_PWM2 = 3'b101,
    TRIG_RSVD = 3'b110,
    TRIG_AUTO = 3'b111
  } trig_src_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_t;
endpackage

// ### hdl/tad_divider.sv
`timescale 1ns/1ps
module tad_divider
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Control
  input wire logic en,
  input wire logic rc_sel,
  input wire logic [7:0] div,
  input wire logic rc_clk,
  // Conversion clock enable
  output logic tad_q
);
  logic [2:0] sync_q;
  logic lev_q;
  logic [7:0] cnt_q;
  logic rc_rise;

  ////////////////////////////////////////////////////////////////
  // RC clock pin: level counts once stages two and three agree
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_q <= 3'h0;
      lev_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], rc_clk};
      if (sync_q[1] == sync_q[2]) lev_q <= sync_q[2];
    end
  end

  assign rc_rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !lev_q;

  // Divider: period of div plus one system cycles, RC ignores div
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 8'h00;
      tad_q <= 1'b0;
    end else if (!en) begin
      cnt_q <= 8'h00;
      tad_q <= 1'b0;
    end else if (rc_sel) begin
      cnt_q <= 8'h00;
      tad_q <= rc_rise;
    end else if (cnt_q >= div) begin
      cnt_q <= 8'h00;
      tad_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      tad_q <= 1'b0;
    end
  end

  tad_gap_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (tad_q && en && !rc_sel && div != 8'h00) ##0 (en && !rc_sel) [*1] |=> !tad_q)
    else $error("conversion clock pulses too close");
  tad_full_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (en && !rc_sel && div == 8'h00) ##1 (en && !rc_sel && div == 8'h00) |=> tad_q)
    else $error("divider of zero must pulse every cycle");
endmodule

// ### hdl/result_formatter.sv
`timescale 1ns/1ps
module result_formatter
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Raw result
  input wire logic load,
  input wire logic res12,
  input wire logic [1:0] fmt,
  input wire logic [11:0] raw,
  input wire logic [1:0] ch,
  // Formatted result
  output logic [15:0] dout_q,
  output logic valid_q,
  output logic [1:0] ch_q
);
  logic [15:0] dout_d;

  // Justification and sign, sign is the inverted top data bit
  always_comb begin
    dout_d = 16'h0000;
    if (res12) begin
      case (fmt)
        2'b00: dout_d = {4'h0, raw};
        2'b01: dout_d = {{5{~raw[11]}}, raw[10:0]};
        2'b10: dout_d = {raw, 4'h0};
        default: dout_d = {~raw[11], raw[10:0], 4'h0};
      endcase
    end else begin
      case (fmt)
        2'b00: dout_d = {6'h00, raw[9:0]};
        2'b01: dout_d = {{7{~raw[9]}}, raw[8:0]};
        2'b10: dout_d = {raw[9:0], 6'h00};
        default: dout_d = {~raw[9], raw[8:0], 6'h00};
      endcase
    end
  end

  // Result holds until the next conversion overwrites it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dout_q <= 16'h0000;
      valid_q <= 1'b0;
      ch_q <= 2'h0;
    end else begin
      valid_q <= load;
      if (load) begin
        dout_q <= dout_d;
        ch_q <= ch;
      end
    end
  end

  fmt10_int_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (load && !res12 && fmt == 2'b00) |=> (dout_q[15:10] == 6'h00 && valid_q))
    else $error("10-bit integer format has nonzero upper bits");
  fmt10_sfrac_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (load && !res12 && fmt == 2'b11) |=>
      (dout_q[15] == !$past(raw[9]) && dout_q[5:0] == 6'h00))
    else $error("10-bit signed fractional format wrong");
  fmt12_frac_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (load && res12 && fmt == 2'b10) |=> (dout_q == {$past(raw), 4'h0}))
    else $error("12-bit fractional format wrong");
  fmt12_sint_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (load && res12 && fmt == 2'b01) |=>
      (dout_q[15:11] == {5{!$past(raw[11])}}))
    else $error("12-bit signed integer sign extension wrong");
endmodule

// ### hdl/adc_sequencer_control.sv
// Functional notes
// - Converter runs only while the enable bit, bit 15, is one.
// - With idle-stop set, the converter halts while the device idles.
// - Build mode picks conversion-order address or input-indexed scatter address.
// - Resolution bit picks 12-bit single channel or 10-bit four channels.
// - 10-bit results formatted per format code, sign is inverted MSB.
// - 12-bit results formatted per format code, sign is inverted bit 11.
// - Trigger field picks what ends sampling; code 110 is reserved.
// - Auto-sample time sets 0 to 31 periods, only with internal counter.
// - Simultaneous bit samples channels together, otherwise one after another.
// - In 12-bit mode simultaneous bit and channel count read zero.
// - Auto-start restarts sampling after the last conversion, else software starts.
// - Software sets sample bit; clearing ends sampling only with software trigger.
// - Done sets at completion, clears at conversion start; software writes zero.
// - Reference field picks internal or external positive and negative references.
// - Scan enable scans the channel 0 positive input during the first set.
// - Channel count converts channel 0, channels 0-1, or channels 0-3.
// - Fill status shows which buffer half is being filled in split mode.
// - Event or DMA increment every rate-plus-one sample/conversion sequences.
// - Split mode alternates fill start between 0x0 and 0x8 per event.
// - Alternate bit swaps between first and second input sets each sample.
// - Clock source bit picks the RC clock, then the divider is ignored.
// - System-derived conversion clock period is divider plus one cycles.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module adc_sequencer_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [1:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Device state and trigger sources
  input wire logic IDLE_MODE,
  input wire logic INT0_PIN,
  input wire logic TMR3_MATCH,
  input wire logic PWM1_TRIG,
  input wire logic TMR5_MATCH,
  input wire logic PWM2_TRIG,
  input wire logic RC_CLK,
  // Converter core data
  input wire logic [11:0] CONV_DATA,
  // Converter control
  output logic CONVERTER_ACTIVE,
  output logic RESOLUTION_12B,
  output logic SAMPLING,
  output logic [3:0] SH_HOLD,
  output logic VREF_POS_EXT,
  output logic VREF_NEG_EXT,
  output logic INPUT_SET_B,
  output logic SCAN_ADVANCE,
  output logic SCAN_RESTART,
  // Results, DMA and events
  output logic [15:0] RESULT_DATA,
  output logic RESULT_VALID,
  output logic [1:0] RESULT_CHANNEL,
  output logic [5:0] DMA_ADDR,
  output logic INT_EVENT
);
  logic [15:0] con1_q;
  logic [15:0] con2_q;
  logic [15:0] con3_q;
  logic [15:0] rdata_q;
  logic done_q;
  logic sample_bit_q;
  logic buffer_fill_status_q;
  logic set_b_q;
  logic active_q;
  logic [3:0] hold_q;
  logic vpos_q;
  logic vneg_q;
  logic scan_adv_q;
  logic scan_rst_q;
  logic [5:0] dma_addr_q;
  logic event_q;
  seq_state_t state_q;
  seq_state_t state_d;
  logic [1:0] ch_q;
  logic [1:0] ch_d;
  logic [4:0] tad_cnt_q;
  logic [3:0] set_cnt_q;
  logic [3:0] ptr_q;
  logic [3:0] inc_q;
  logic [2:0] int0_sync_q;
  logic int0_lev_q;
  logic tad;

  ////////////////////////////////////////////////////////////////
  // Field decode
  logic con_on;
  logic idle_stop;
  logic dma_build;
  logic res12;
  logic [1:0] result_format;
  trig_src_t trig_src;
  logic simultaneous_sample_eff;
  logic auto_sample_start;
  logic [2:0] vref_sel;
  logic scan_en;
  logic [1:0] chcnt_eff;
  logic [3:0] inc_rate;
  logic split_buffer_mode;
  logic alternate_sample;
  logic [4:0] samc;
  logic run;
  logic [1:0] last_ch;
  logic [4:0] conv_len;

  assign con_on = con1_q[CON1_ON];
  assign idle_stop = con1_q[CON1_IDLE_STOP];
  assign dma_build = con1_q[CON1_DMA_BUILD];
  // Mode is only switched while off, so no mid-conversion change
  assign res12 = con1_q[CON1_RES12];
  assign result_format = con1_q[CON1_FORM_LO +: 2];
  assign trig_src = trig_src_t'(con1_q[CON1_TRIG_LO +: 3]);
  assign simultaneous_sample_eff = con1_q[CON1_SIMULTANEOUS_SAMPLE] && !res12;
  assign auto_sample_start = con1_q[CON1_AUTO_SAMPLE_START];
  assign vref_sel = con2_q[CON2_VREF_LO +: 3];
  assign scan_en = con2_q[CON2_SCAN];
  assign chcnt_eff = res12 ? 2'b00 : con2_q[CON2_CHCNT_LO +: 2];
  assign inc_rate = con2_q[CON2_RATE_LO +: 4];
  assign split_buffer_mode = con2_q[CON2_SPLIT_BUFFER_MODE];
  assign alternate_sample = con2_q[CON2_ALTERNATE_SAMPLE];
  assign samc = con3_q[CON3_SAMC_LO +: 5];
  assign run = con_on && !(idle_stop && IDLE_MODE);
  assign last_ch = chcnt_eff[1] ? 2'h3 : {1'b0, chcnt_eff[0]};
  assign conv_len = res12 ? CONV_TAD_12B : CONV_TAD_10B;

  ////////////////////////////////////////////////////////////////
  // Register writes and software strobes
  logic con1_wr;
  logic sw_sample_bit_set;
  logic sw_sample_bit_clr;

  assign con1_wr = REG_WR && (REG_ADDR == ADDR_CON1);
  assign sw_sample_bit_set = con1_wr && REG_WDATA[CON1_SAMPLE_BIT] && !auto_sample_start;
  assign sw_sample_bit_clr = con1_wr && !REG_WDATA[CON1_SAMPLE_BIT];

  // Control registers; status bits live in their own flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      con1_q <= CON_RESET;
      con2_q <= CON_RESET;
      con3_q <= CON_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        ADDR_CON1: con1_q <= REG_WDATA & CON1_STORE_MASK;
        ADDR_CON2: con2_q <= REG_WDATA & CON2_STORE_MASK;
        ADDR_CON3: con3_q <= REG_WDATA & CON3_STORE_MASK;
        default: ;
      endcase
    end
  end

  // Read data stand for the single cycle after the strobe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        ADDR_CON1: begin
          rdata_q <= con1_q;
          rdata_q[CON1_SIMULTANEOUS_SAMPLE] <= simultaneous_sample_eff;
          rdata_q[CON1_SAMPLE_BIT] <= sample_bit_q;
          rdata_q[CON1_DONE] <= done_q;
        end
        ADDR_CON2: begin
          rdata_q <= con2_q;
          rdata_q[CON2_CHCNT_LO +: 2] <= chcnt_eff;
          rdata_q[CON2_BUFFER_FILL_STATUS] <= buffer_fill_status_q;
        end
        ADDR_CON3: rdata_q <= con3_q;
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // External edge pin: three stages, settled level, rising edge
  logic int0_edge;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      int0_sync_q <= 3'h0;
      int0_lev_q <= 1'b0;
    end else begin
      int0_sync_q <= {int0_sync_q[1:0], INT0_PIN};
      if (int0_sync_q[1] == int0_sync_q[2]) int0_lev_q <= int0_sync_q[2];
    end
  end

  assign int0_edge = (int0_sync_q[1] == int0_sync_q[2]) && int0_sync_q[2] && !int0_lev_q;

  // Conversion clock enable
  tad_divider u_div (
    .CLK(CLK),
    .RESETN(RESETN),
    .en(run),
    .rc_sel(con3_q[CON3_RC]),
    .div(con3_q[CON3_DIV_LO +: 8]),
    .rc_clk(RC_CLK),
    .tad_q(tad)
  );

  ////////////////////////////////////////////////////////////////
  // Trigger that ends sampling
  logic trig_hit;

  always_comb begin
    trig_hit = 1'b0;
    case (trig_src)
      TRIG_SOFT: trig_hit = sw_sample_bit_clr;
      TRIG_INT0: trig_hit = int0_edge;
      TRIG_TMR3: trig_hit = TMR3_MATCH;
      TRIG_PWM1: trig_hit = PWM1_TRIG;
      TRIG_TMR5: trig_hit = TMR5_MATCH;
      TRIG_PWM2: trig_hit = PWM2_TRIG;
      TRIG_AUTO: trig_hit = (tad_cnt_q >= samc);
      default: trig_hit = 1'b0;
    endcase
  end

  logic conv_step;
  logic conv_last;
  logic conv_start;

  assign conv_step = run && (state_q == ST_CONVERT) && tad && (tad_cnt_q == conv_len - 5'h01);
  assign conv_last = conv_step && (ch_q == last_ch);
  assign conv_start = (state_q == ST_SAMPLE) && (state_d == ST_CONVERT);

  // Sequencer: sample, then one conversion per active channel
  always_comb begin
    state_d = state_q;
    ch_d = ch_q;
    case (state_q)
      ST_IDLE: begin
        ch_d = 2'h0;
        if (auto_sample_start || sw_sample_bit_set) state_d = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (trig_hit) state_d = ST_CONVERT;
      end
      ST_CONVERT: begin
        if (conv_last) begin
          ch_d = 2'h0;
          state_d = auto_sample_start ? ST_SAMPLE : ST_IDLE;
        end else if (conv_step) begin
          ch_d = ch_q + 2'h1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!run) begin
      state_d = ST_IDLE;
      ch_d = 2'h0;
    end
  end

  // Period counter restarts on every phase change
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      ch_q <= 2'h0;
      tad_cnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      ch_q <= ch_d;
      if (!run || state_d != state_q || conv_step) tad_cnt_q <= 5'h00;
      else if (tad && tad_cnt_q != 5'h1f) tad_cnt_q <= tad_cnt_q + 5'h01;
    end
  end

  // Sample bit follows the phase; done set wins over software clear
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sample_bit_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sample_bit_q <= (state_d == ST_SAMPLE);
      if (conv_last) done_q <= 1'b1;
      else if (conv_start) done_q <= 1'b0;
      else if (con1_wr && !REG_WDATA[CON1_DONE]) done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sample/hold control and analog steering
  logic [3:0] hold_mask;

  always_comb begin
    hold_mask = 4'h0;
    if (state_d == ST_CONVERT) begin
      if (simultaneous_sample_eff) hold_mask = chcnt_eff[1] ? 4'hf : 4'h3;
      else hold_mask = 4'h1 << ch_d;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      hold_q <= 4'h0;
      active_q <= 1'b0;
      vpos_q <= 1'b0;
      vneg_q <= 1'b0;
    end else begin
      hold_q <= hold_mask;
      active_q <= run;
      vpos_q <= (vref_sel == 3'b001) || (vref_sel == 3'b011);
      vneg_q <= (vref_sel == 3'b010) || (vref_sel == 3'b011);
    end
  end

  // Input set alternation and scan stepping per sample set
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      set_b_q <= 1'b0;
      scan_adv_q <= 1'b0;
      scan_rst_q <= 1'b0;
    end else begin
      if (!alternate_sample) set_b_q <= 1'b0;
      else if (conv_last) set_b_q <= !set_b_q;
      scan_adv_q <= conv_start && scan_en && !set_b_q;
      scan_rst_q <= conv_last && scan_en && (set_cnt_q == inc_rate);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Event rate, buffer halves and DMA addressing
  logic rate_hit;
  logic buffer_fill_status_next;

  assign rate_hit = conv_last && (set_cnt_q == inc_rate);
  assign buffer_fill_status_next = split_buffer_mode && !buffer_fill_status_q;

  // Fill pointer restarts at the half now being filled
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      set_cnt_q <= 4'h0;
      event_q <= 1'b0;
      buffer_fill_status_q <= 1'b0;
      ptr_q <= 4'h0;
      inc_q <= 4'h0;
      dma_addr_q <= 6'h00;
    end else begin
      event_q <= rate_hit;
      if (!split_buffer_mode) buffer_fill_status_q <= 1'b0;
      if (rate_hit) begin
        set_cnt_q <= 4'h0;
        inc_q <= inc_q + 4'h1;
        buffer_fill_status_q <= buffer_fill_status_next;
        ptr_q <= buffer_fill_status_next ? HALF_BASE : 4'h0;
      end else if (conv_last) begin
        set_cnt_q <= set_cnt_q + 4'h1;
      end
      if (conv_step && !rate_hit) ptr_q <= ptr_q + 4'h1;
      if (conv_step) begin
        if (dma_build) dma_addr_q <= {2'b00, ptr_q};
        else dma_addr_q <= {ch_q, inc_q};
      end
    end
  end

  // Result formatting, loaded as each channel completes
  result_formatter u_fmt (
    .CLK(CLK),
    .RESETN(RESETN),
    .load(conv_step),
    .res12(res12),
    .fmt(result_format),
    .raw(CONV_DATA),
    .ch(ch_q),
    .dout_q(RESULT_DATA),
    .valid_q(RESULT_VALID),
    .ch_q(RESULT_CHANNEL)
  );

  assign REG_RDATA = rdata_q;
  assign CONVERTER_ACTIVE = active_q;
  assign RESOLUTION_12B = con1_q[CON1_RES12];
  assign SAMPLING = sample_bit_q;
  assign SH_HOLD = hold_q;
  assign VREF_POS_EXT = vpos_q;
  assign VREF_NEG_EXT = vneg_q;
  assign INPUT_SET_B = set_b_q;
  assign SCAN_ADVANCE = scan_adv_q;
  assign SCAN_RESTART = scan_rst_q;
  assign DMA_ADDR = dma_addr_q;
  assign INT_EVENT = event_q;

  ////////////////////////////////////////////////////////////////
  // Checks
  off_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !con_on |=> (state_q == ST_IDLE && !SAMPLING && !CONVERTER_ACTIVE))
    else $error("converter active while disabled");
  idle_halt_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (idle_stop && IDLE_MODE) |=> (state_q == ST_IDLE && SH_HOLD == 4'h0))
    else $error("converter running in idle with idle-stop set");
  done_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
    conv_start |=> (!done_q && state_q == ST_CONVERT))
    else $error("done not cleared at conversion start");
  done_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
    conv_last |=> done_q)
    else $error("done not set at completion");
  trig_tmr3_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_SAMPLE && run && trig_src == TRIG_TMR3 && TMR3_MATCH)
      |=> (state_q == ST_CONVERT && !SAMPLING))
    else $error("timer compare did not start conversion");
  trig_rsvd_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_SAMPLE && trig_src == TRIG_RSVD) |=> state_q != ST_CONVERT)
    else $error("reserved trigger started conversion");
  auto_time_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_SAMPLE && trig_src == TRIG_AUTO && tad_cnt_q < samc)
      |=> state_q != ST_CONVERT)
    else $error("auto sample ended early");
  event_rate_a: assert property (@(posedge CLK) disable iff (!RESETN)
    conv_last |=> (INT_EVENT == ($past(set_cnt_q) == $past(inc_rate))))
    else $error("event raised at wrong sequence count");
  buffer_fill_status_swap_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (rate_hit && split_buffer_mode) |=> (buffer_fill_status_q != $past(buffer_fill_status_q)))
    else $error("buffer half did not alternate");
  alt_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (conv_last && alternate_sample) |=> (INPUT_SET_B != $past(INPUT_SET_B)))
    else $error("input set did not alternate");
  res12_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (REG_RD && REG_ADDR == ADDR_CON2 && res12) |=> REG_RDATA[9:8] == 2'b00)
    else $error("channel count readable in 12-bit mode");
  seq_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_q == ST_CONVERT && $past(simultaneous_sample_eff) == 1'b0) |-> $onehot(SH_HOLD))
    else $error("sequential mode holds more than one channel");
endmodule

// ### verif/adc_far_side.sv
`timescale 1ns/1ps
module adc_far_side (
  // Clock
  input wire logic CLK,
  // Bench commands
  input wire logic fire,
  input wire logic [11:0] level,
  // Core data and trigger sources
  output logic [11:0] CONV_DATA,
  output logic TMR3_MATCH,
  output logic PWM1_TRIG,
  output logic TMR5_MATCH,
  output logic PWM2_TRIG,
  output logic RC_CLK
);
  // Core result follows the analog level the bench sets
  assign CONV_DATA = level;
  // Timer compare is a one-cycle pulse, as a real timer gives
  always_ff @(posedge CLK) begin
    TMR3_MATCH <= fire;
  end
  // Unused sources stay quiet; RC clock stands still
  assign PWM1_TRIG = 1'b0;
  assign TMR5_MATCH = 1'b0;
  assign PWM2_TRIG = 1'b0;
  assign RC_CLK = 1'b0;
endmodule

// ### verif/adc_sequencer_control_tb_top.sv
`timescale 1ns/1ps
module adc_sequencer_control_tb_top;
  import adc_ctrl_pkg::*;
  logic CLK = 0, RESETN = 0, REG_WR = 0, REG_RD = 0, IDLE_MODE = 0, INT0_PIN = 0, fire = 0;
  logic [1:0] REG_ADDR = 2'h0;
  logic [15:0] REG_WDATA = 16'h0000, REG_RDATA, RESULT_DATA, rd_q;
  logic [11:0] level = 12'h155, CONV_DATA;
  logic TMR3_MATCH, PWM1_TRIG, TMR5_MATCH, PWM2_TRIG, RC_CLK, CONVERTER_ACTIVE, SAMPLING;
  logic VREF_POS_EXT, VREF_NEG_EXT, RESULT_VALID;
  logic INPUT_SET_B, SCAN_RESTART, INT_EVENT;
  logic [1:0] RESULT_CHANNEL, ev_q;
  logic [5:0] DMA_ADDR;
  int failures = 0, tests_run = 0;
  always #12.5 CLK = ~CLK;
  adc_sequencer_control DUT (.CLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
    .REG_RDATA, .IDLE_MODE, .INT0_PIN, .TMR3_MATCH, .PWM1_TRIG, .TMR5_MATCH, .PWM2_TRIG,
    .RC_CLK, .CONV_DATA, .CONVERTER_ACTIVE, .RESOLUTION_12B(), .SAMPLING, .SH_HOLD(),
    .VREF_POS_EXT, .VREF_NEG_EXT, .INPUT_SET_B, .SCAN_ADVANCE(), .SCAN_RESTART,
    .RESULT_DATA, .RESULT_VALID, .RESULT_CHANNEL, .DMA_ADDR, .INT_EVENT);
  adc_far_side FAR (.CLK, .fire, .level, .CONV_DATA, .TMR3_MATCH, .PWM1_TRIG, .TMR5_MATCH,
    .PWM2_TRIG, .RC_CLK);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // Register port: one-cycle strobes, data in the following cycle only
  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 rd_q = REG_RDATA;
  endtask
  // Bounded wait; a missing result counts as a mismatch
  task automatic wres();
    int i;
    i = 0;
    while (RESULT_VALID !== 1'b1 && i < 2000) begin
      cyc(1);
      i++;
    end
    // Event pulses stand only beside the valid pulse
    ev_q = {SCAN_RESTART, INT_EVENT};
    chk("result_valid", 16'h1, {15'h0, RESULT_VALID});
    cyc(1);
  endtask
  // Expected 10-bit layout per format code
  function automatic logic [15:0] fmt10(logic [1:0] f, logic [9:0] d);
    case (f)
      2'h0: return {6'h00, d};
      2'h1: return {{7{~d[9]}}, d[8:0]};
      2'h2: return {d, 6'h00};
      default: return {~d[9], d[8:0], 6'h00};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(2'h3, 16'hffff);
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk("reset_value", 16'h0000, rd_q);
    end
    wr(2'h2, 16'hffff);
    rd(2'h2);
    chk("control_three", 16'h9fff, rd_q);
    wr(2'h0, 16'h0408);
    wr(2'h1, 16'h0300);
    rd(2'h0);
    chk("simultaneous_sample_12b", 16'h0400, rd_q);
    rd(2'h1);
    chk("chcnt_12b", 16'h0000, rd_q);
    wr(2'h0, 16'h0000);
    $display("test regs done");
  endtask
  task automatic t_fmt();
    wr(2'h2, 16'h0200);
    wr(2'h1, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      wr(2'h0, 16'h80e4 | (f << 8));
      wres();
      wres();
      chk("format_10b", fmt10(f[1:0], level[9:0]), RESULT_DATA);
    end
    wr(2'h0, 16'h0000);
    cyc(3);
    chk("converter_off", 16'h0, {15'h0, CONVERTER_ACTIVE});
    wr(2'h0, 16'h87e4);
    wres();
    wres();
    chk("format_12b", {~level[11], level[10:0], 4'h0}, RESULT_DATA);
    wr(2'h0, 16'h0000);
    $display("test format done");
  endtask
  task automatic t_soft();
    // Sample request counts only once the converter is already on
    wr(2'h0, 16'h8000);
    wr(2'h0, 16'h8002);
    cyc(2);
    chk("sampling_sw", 16'h1, {15'h0, SAMPLING});
    wr(2'h0, 16'h8000);
    wres();
    cyc(3);
    rd(2'h0);
    chk("done_set", 16'h8001, rd_q);
    wr(2'h0, 16'h8000);
    rd(2'h0);
    chk("done_clear", 16'h8000, rd_q);
    $display("test software trigger done");
  endtask
  task automatic t_trig();
    wr(2'h0, 16'h8042);
    cyc(20);
    chk("await_timer", 16'h1, {15'h0, SAMPLING});
    @(posedge CLK) fire <= 1'b1;
    @(posedge CLK) fire <= 1'b0;
    wres();
    wr(2'h0, 16'h8022);
    INT0_PIN <= 1'b1;
    wres();
    @(posedge CLK) INT0_PIN <= 1'b0;
    wr(2'h0, 16'h80c2);
    cyc(150);
    chk("reserved_trig", 16'h1, {15'h0, SAMPLING});
    wr(2'h0, 16'ha000);
    IDLE_MODE <= 1'b1;
    cyc(3);
    chk("idle_stop", 16'h0, {15'h0, CONVERTER_ACTIVE});
    wr(2'h0, 16'h8000);
    cyc(3);
    chk("idle_run", 16'h1, {15'h0, CONVERTER_ACTIVE});
    IDLE_MODE <= 1'b0;
    $display("test triggers and idle done");
  endtask
  // Four channels in order, split buffer, event every second sequence
  task automatic t_seq();
    wr(2'h1, 16'h0607);
    wr(2'h0, 16'h90e4);
    for (int k = 0; k < 9; k++) begin
      wres();
      chk("channel", k % 4, {14'h0, RESULT_CHANNEL});
      chk("dma_addr", k, {10'h0, DMA_ADDR});
      chk("input_set", ((k + 1) >> 2) & 1, {15'h0, INPUT_SET_B});
      chk("event", (k == 7) ? 3 : 0, {14'h0, ev_q});
    end
    rd(2'h1);
    chk("fill_status", 16'h0687, rd_q);
    wr(2'h0, 16'h0000);
    $display("test sequence done");
  endtask
  task automatic t_vref();
    for (int v = 0; v < 8; v++) begin
      wr(2'h1, v << 13);
      cyc(2);
      chk("vref", {14'h0, v[0] & ~v[2], v[1] & ~v[2]}, {14'h0, VREF_POS_EXT, VREF_NEG_EXT});
    end
    $display("test references done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Run well beyond the expected six hundred-odd cycles
  initial begin
    #500000;
    failures++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs();
    t_fmt();
    t_soft();
    t_trig();
    t_seq();
    t_vref();
    report_and_stop();
  end
endmodule
